// ==== rtl/mmc_pkg.sv ====
`default_nettype none

package mmc_pkg;

   // ----------
   // Clock and timing
   // ----------
   localparam int CLK_PERIOD_NS = 10;
   localparam int INIT_TIME_MS = 2000;
   localparam int INIT_CYC_DEF = INIT_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int RESET_MIN_US = 10;
   localparam int RESET_MIN_CYC_DEF = (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_US = 20;
   localparam int RESET_PULSE_CYC_DEF = (RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int SCL_QUARTER_CYC_DEF = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

   // ----------
   // Serial bus and memory map
   // ----------
   localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
   localparam int MAP_DEPTH_DEF = 8;
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h01;
   localparam logic [7:0] ADDR_CTRL = 8'h02;
   localparam int STATUS_DNR_BIT = 0;
   localparam int FLAG_RESET_DONE = 0;
   localparam int FLAG_FAULT = 1;

   // ----------
   // Pin capture positions
   // ----------
   localparam int D_PIN_SCL = 0;
   localparam int D_PIN_SDA = 1;
   localparam int D_PIN_SEL = 2;
   localparam int D_PIN_RST = 3;
   localparam int D_PIN_LP = 4;
   localparam logic [4:0] D_PIN_IDLE = 5'h0f;
   localparam int H_PIN_SDA = 0;
   localparam int H_PIN_PRES = 1;
   localparam int H_PIN_ATTN = 2;
   localparam logic [2:0] H_PIN_IDLE = 3'h7;

endpackage : mmc_pkg

`default_nettype wire

// ==== rtl/mmc_link_if.sv ====
`default_nettype none

interface mmc_link_if;

   // ----------
   // Driver sides
   // ----------
   logic scl_host_o;
   logic scl_host_oe_n;
   logic sda_host_o;
   logic sda_host_oe_n;
   logic sda_dev_o;
   logic sda_dev_oe_n;
   logic module_select_n;
   logic module_reset_n;
   logic low_power_request;
   logic present_o;
   logic present_oe_n;
   logic attention_o;
   logic attention_oe_n;

   // ----------
   // Resolved wires, host board pull-ups
   // ----------
   logic scl;
   logic sda;
   logic module_present_n;
   logic attention_n;

   assign scl = scl_host_oe_n ? 1'b1 : scl_host_o;
   assign sda = (sda_host_oe_n ? 1'b1 : sda_host_o) & (sda_dev_oe_n ? 1'b1 : sda_dev_o);
   assign module_present_n = present_oe_n ? 1'b1 : present_o;
   assign attention_n = attention_oe_n ? 1'b1 : attention_o;

   modport dev (
      input scl, sda, module_select_n, module_reset_n, low_power_request,
      output sda_dev_o, sda_dev_oe_n, present_o, present_oe_n, attention_o, attention_oe_n
   );

   modport host (
      output scl_host_o, scl_host_oe_n, sda_host_o, sda_host_oe_n,
      output module_select_n, module_reset_n, low_power_request,
      input sda, module_present_n, attention_n
   );

endinterface : mmc_link_if

`default_nettype wire

// ==== rtl/mmc_module_end.sv ====
`default_nettype none

module mmc_module_end
   import mmc_pkg::*;
#(
   parameter int MAP_DEPTH = MAP_DEPTH_DEF,
   parameter int RESET_MIN_CYC = RESET_MIN_CYC_DEF,
   parameter int INIT_CYC = INIT_CYC_DEF,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Link to host board
   mmc_link_if.dev link,
   // Module core side
   input wire logic fault_event,
   output logic module_ready,
   output logic high_power_allow,
   output logic [7:0] ctrl_byte
);

   // ----------
   // Sizes and checks
   // ----------
   localparam int PW = $clog2(MAP_DEPTH);
   localparam int RCW = $clog2(RESET_MIN_CYC + 1);
   localparam int ICW = $clog2(INIT_CYC + 1);

   if (MAP_DEPTH < 3 || MAP_DEPTH > 128 || RESET_MIN_CYC < 1 || INIT_CYC < 2) begin : g_bad
      $error("mmc_module_end: unsupported parameter values");
   end

   // ----------
   // State
   // ----------
   typedef enum logic [2:0] {B_IDLE, B_RX, B_ACK, B_TX, B_TXACK} mmc_bus_st_t;

   typedef struct packed {
      logic [2:0][4:0] sync;
      logic [4:0] pin;
      logic [RCW-1:0] rst_cnt;
      logic init_busy;
      logic [ICW-1:0] init_cnt;
      logic [7:0] flags;
      logic attn;
      logic [MAP_DEPTH-1:0][7:0] mem;
      mmc_bus_st_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rw;
      logic addr_phase;
      logic first_data;
      logic sda_low;
      logic hp_allow;
   } mmc_dev_state_t;

   mmc_dev_state_t r_reg;
   mmc_dev_state_t r_next;

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic sda_in;
   logic full_reset;
   logic set_done;
   logic clear_flags;
   logic writable;
   logic [7:0] rd_byte;

   // ----------
   // Next-state logic
   // ----------
   always_comb begin
      r_next = r_reg;
      set_done = 1'b0;
      clear_flags = 1'b0;

      // Three-stage capture of every pin, accepted once stages agree
      r_next.sync[0] = {link.low_power_request, link.module_reset_n, link.module_select_n,
                        link.sda, link.scl};
      r_next.sync[1] = r_reg.sync[0];
      r_next.sync[2] = r_reg.sync[1];
      for (int i = 0; i < 5; i++) begin
         if (r_reg.sync[1][i] == r_reg.sync[2][i]) begin
            r_next.pin[i] = r_reg.sync[2][i];
         end
      end

      // Bus edges and conditions on the filtered levels
      scl_rise = ~r_reg.pin[D_PIN_SCL] & r_next.pin[D_PIN_SCL];
      scl_fall = r_reg.pin[D_PIN_SCL] & ~r_next.pin[D_PIN_SCL];
      start_cond = r_reg.pin[D_PIN_SCL] & r_next.pin[D_PIN_SCL]
                   & r_reg.pin[D_PIN_SDA] & ~r_next.pin[D_PIN_SDA];
      stop_cond = r_reg.pin[D_PIN_SCL] & r_next.pin[D_PIN_SCL]
                  & ~r_reg.pin[D_PIN_SDA] & r_next.pin[D_PIN_SDA];
      sda_in = r_next.pin[D_PIN_SDA];

      if (r_reg.pin[D_PIN_RST]) begin
         r_next.rst_cnt = '0;
      end else if (r_reg.rst_cnt != RCW'(RESET_MIN_CYC)) begin
         r_next.rst_cnt = r_reg.rst_cnt + 1'b1;
      end
      full_reset = (r_reg.rst_cnt == RCW'(RESET_MIN_CYC));

      // complete reset, held while pin stays low
      if (full_reset) begin
         r_next.init_busy = 1'b1;
         r_next.init_cnt = '0;
         r_next.flags = '0;
         r_next.mem = '0;
         r_next.ptr = '0;
      end else if (r_reg.init_busy) begin
         if (r_reg.init_cnt == ICW'(INIT_CYC - 1)) begin
            r_next.init_busy = 1'b0;
            set_done = 1'b1;
         end else begin
            r_next.init_cnt = r_reg.init_cnt + 1'b1;
         end
      end

      // Map read data; status byte reflects the not-ready state
      rd_byte = 8'h00;
      if (r_reg.ptr == ADDR_STATUS) begin
         rd_byte[STATUS_DNR_BIT] = r_reg.init_busy;
      end else if (r_reg.ptr == ADDR_FLAGS) begin
         rd_byte = r_reg.flags;
      end else if (r_reg.ptr < 8'(MAP_DEPTH)) begin
         rd_byte = r_reg.mem[r_reg.ptr[PW-1:0]];
      end
      // Status and flag bytes are read-only
      writable = (r_reg.ptr >= ADDR_CTRL) && (r_reg.ptr < 8'(MAP_DEPTH));

      // deselect drops the transfer and frees the data line
      if (r_reg.pin[D_PIN_SEL] || full_reset) begin
         r_next.st = B_IDLE;
         r_next.sda_low = 1'b0;
      end else if (start_cond) begin
         r_next.st = B_RX;
         r_next.bitcnt = '0;
         r_next.addr_phase = 1'b1;
         r_next.sda_low = 1'b0;
      end else if (stop_cond) begin
         r_next.st = B_IDLE;
         r_next.sda_low = 1'b0;
      end else begin
         unique case (r_reg.st)
            B_IDLE: begin
            end
            B_RX: begin
               if (scl_rise) begin
                  r_next.shreg = {r_reg.shreg[6:0], sda_in};
                  r_next.bitcnt = r_reg.bitcnt + 4'h1;
               end else if (scl_fall && r_reg.bitcnt == 4'h8) begin
                  r_next.bitcnt = '0;
                  r_next.sda_low = 1'b1;
                  r_next.st = B_ACK;
                  if (r_reg.addr_phase) begin
                     r_next.addr_phase = 1'b0;
                     r_next.first_data = 1'b1;
                     r_next.rw = r_reg.shreg[0];
                     // Foreign address: stay silent until next start
                     if (r_reg.shreg[7:1] != DEV_ADDR) begin
                        r_next.sda_low = 1'b0;
                        r_next.st = B_IDLE;
                     end
                  end else if (r_reg.first_data) begin
                     r_next.first_data = 1'b0;
                     r_next.ptr = r_reg.shreg;
                  end else begin
                     if (writable) begin
                        r_next.mem[r_reg.ptr[PW-1:0]] = r_reg.shreg;
                     end
                     r_next.ptr = r_reg.ptr + 8'h01;
                  end
               end
            end
            B_ACK: begin
               if (scl_fall) begin
                  if (r_reg.rw) begin
                     r_next.shreg = rd_byte;
                     r_next.sda_low = ~rd_byte[7];
                     r_next.bitcnt = 4'h1;
                     r_next.ptr = r_reg.ptr + 8'h01;
                     r_next.st = B_TX;
                     clear_flags = (r_reg.ptr == ADDR_FLAGS);
                  end else begin
                     r_next.sda_low = 1'b0;
                     r_next.st = B_RX;
                  end
               end
            end
            B_TX: begin
               if (scl_fall) begin
                  if (r_reg.bitcnt == 4'h8) begin
                     r_next.sda_low = 1'b0;
                     r_next.st = B_TXACK;
                  end else begin
                     r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                     r_next.sda_low = ~r_reg.shreg[6];
                     r_next.bitcnt = r_reg.bitcnt + 4'h1;
                  end
               end
            end
            B_TXACK: begin
               // Host not-acknowledge ends the read burst
               if (scl_rise) begin
                  r_next.st = sda_in ? B_IDLE : B_ACK;
               end
            end
         endcase
      end

      // Sticky flags: clear on read, a same-cycle event still lands
      if (clear_flags) begin
         r_next.flags = '0;
      end
      // reset-done flag, not-ready bit cleared together
      if (set_done) begin
         r_next.flags[FLAG_RESET_DONE] = 1'b1;
      end
      if (fault_event && !full_reset) begin
         r_next.flags[FLAG_FAULT] = 1'b1;
      end
      r_next.attn = |r_next.flags;

      // high power only when not requested low
      r_next.hp_allow = ~r_reg.pin[D_PIN_LP] & ~r_reg.init_busy;
   end

   // ----------
   // State register
   // ----------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r_reg <= '0;
         r_reg.sync <= {3{D_PIN_IDLE}};
         r_reg.pin <= D_PIN_IDLE;
         r_reg.init_busy <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------
   // Pin drivers, all sink-only
   // ----------
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe_n = ~r_reg.sda_low;
   assign link.present_o = 1'b0;
   assign link.present_oe_n = 1'b0;
   assign link.attention_o = 1'b0;
   assign link.attention_oe_n = ~r_reg.attn;

   // Core side outputs
   assign module_ready = ~r_reg.init_busy;
   assign high_power_allow = r_reg.hp_allow;
   assign ctrl_byte = r_reg.mem[ADDR_CTRL[PW-1:0]];

endmodule : mmc_module_end

`default_nettype wire

// ==== rtl/mmc_host_end.sv ====
`default_nettype none

module mmc_host_end
   import mmc_pkg::*;
#(
   parameter int QUARTER_CYC = SCL_QUARTER_CYC_DEF,
   parameter int RESET_PULSE_CYC = RESET_PULSE_CYC_DEF,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Link to module
   mmc_link_if.host link,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_nack,
   output logic [7:0] rsp_rdata,
   // Module control and status
   input wire logic reset_request,
   input wire logic low_power_in,
   output logic module_present,
   output logic module_ready,
   output logic event_valid,
   output logic [7:0] event_flags
);

   localparam int QW = $clog2(QUARTER_CYC + 1);
   localparam int PCW = $clog2(RESET_PULSE_CYC + 1);

   if (QUARTER_CYC < 8 || RESET_PULSE_CYC < 2) begin : g_bad
      $error("mmc_host_end: unsupported parameter values");
   end

   // ----------
   // State
   // ----------
   typedef enum logic [1:0] {K_START, K_BYTE, K_READ, K_STOP} mmc_sym_t;

   typedef struct packed {
      logic [2:0][2:0] sync;
      logic [2:0] pin;
      logic busy;
      logic [2:0] step;
      logic [1:0] phase;
      logic [3:0] bitn;
      logic [QW-1:0] qcnt;
      mmc_sym_t kind;
      logic wr;
      logic auto_rd;
      logic [7:0] reg_a;
      logic [7:0] data;
      logic [7:0] shreg;
      logic nack;
      logic scl_low;
      logic sda_low;
      logic sel_n;
      logic rst_low;
      logic [PCW-1:0] rst_cnt;
      logic pending;
      logic lp;
      logic rsp_valid;
      logic evt_valid;
      logic [7:0] rsp_data;
   } mmc_host_state_t;

   mmc_host_state_t r_reg;
   mmc_host_state_t r_next;

   // Symbol and byte for a step of a single-byte write or read
   function automatic logic [9:0] sym_at(input logic [2:0] step, input logic wr,
                                         input logic [7:0] reg_a, input logic [7:0] data);
      logic [9:0] s;
      s = {K_STOP, 8'h00};
      unique case (step)
         3'd0: s = {K_START, 8'h00};
         3'd1: s = {K_BYTE, DEV_ADDR, 1'b0};
         3'd2: s = {K_BYTE, reg_a};
         3'd3: s = wr ? {K_BYTE, data} : {K_START, 8'h00};
         3'd4: s = wr ? {K_STOP, 8'h00} : {K_BYTE, DEV_ADDR, 1'b1};
         3'd5: s = {K_READ, 8'h00};
         default: s = {K_STOP, 8'h00};
      endcase
      return s;
   endfunction : sym_at

   logic tick;
   logic sym_end;
   logic [2:0] nstep;
   logic [9:0] nsym;

   // ----------
   // Next-state logic
   // ----------
   always_comb begin
      r_next = r_reg;
      r_next.rsp_valid = 1'b0;
      r_next.evt_valid = 1'b0;
      r_next.lp = low_power_in;
      tick = 1'b0;
      sym_end = 1'b0;
      nstep = r_reg.step;
      nsym = 10'h000;

      // Three-stage capture of module pins
      r_next.sync[0] = {link.attention_n, link.module_present_n, link.sda};
      r_next.sync[1] = r_reg.sync[0];
      r_next.sync[2] = r_reg.sync[1];
      for (int i = 0; i < 3; i++) begin
         if (r_reg.sync[1][i] == r_reg.sync[2][i]) begin
            r_next.pin[i] = r_reg.sync[2][i];
         end
      end

      // Reset pulse generation, then wait for completion
      if (r_reg.rst_low) begin
         if (r_reg.rst_cnt == PCW'(RESET_PULSE_CYC - 1)) begin
            r_next.rst_low = 1'b0;
         end else begin
            r_next.rst_cnt = r_reg.rst_cnt + 1'b1;
         end
      end else if (reset_request && !r_reg.busy) begin
         r_next.rst_low = 1'b1;
         r_next.rst_cnt = '0;
         r_next.pending = 1'b1;
      // status untrusted until attention after reset
      end else if (r_reg.pending && !r_reg.pin[H_PIN_ATTN]) begin
         r_next.pending = 1'b0;
      end

      // Launch: pending attention is served before user commands
      if (!r_reg.busy && !r_reg.rst_low && !reset_request) begin
         // read flag byte to learn the cause
         if (!r_reg.pin[H_PIN_ATTN]) begin
            r_next.busy = 1'b1;
            r_next.auto_rd = 1'b1;
            r_next.wr = 1'b0;
            r_next.reg_a = ADDR_FLAGS;
         end else if (cmd_valid && cmd_ready) begin
            r_next.busy = 1'b1;
            r_next.auto_rd = 1'b0;
            r_next.wr = cmd_write;
            r_next.reg_a = cmd_addr;
            r_next.data = cmd_wdata;
         end
         r_next.sel_n = ~r_next.busy;
         r_next.step = '0;
         r_next.phase = '0;
         r_next.qcnt = '0;
         r_next.bitn = '0;
         r_next.nack = 1'b0;
         r_next.kind = K_START;
      end

      // Bit engine: four quarter phases per bit or condition
      if (r_reg.busy) begin
         if (r_reg.qcnt == QW'(QUARTER_CYC - 1)) begin
            r_next.qcnt = '0;
            tick = 1'b1;
         end else begin
            r_next.qcnt = r_reg.qcnt + 1'b1;
         end
      end
      if (tick) begin
         r_next.phase = r_reg.phase + 2'h1;
         unique case (r_reg.phase)
            2'd0: begin
               r_next.scl_low = 1'b1;
               r_next.sda_low = (r_reg.kind == K_STOP)
                                || (r_reg.kind == K_BYTE && r_reg.bitn < 4'h8 && !r_reg.shreg[7]);
            end
            2'd1: begin
               r_next.scl_low = 1'b0;
            end
            2'd2: begin
               if (r_reg.kind == K_START) begin
                  r_next.sda_low = 1'b1;
               end else if (r_reg.kind == K_STOP) begin
                  r_next.sda_low = 1'b0;
               end else if (r_reg.bitn < 4'h8) begin
                  r_next.shreg = {r_reg.shreg[6:0], r_reg.pin[H_PIN_SDA]};
               end else if (r_reg.kind == K_BYTE) begin
                  r_next.nack = r_reg.pin[H_PIN_SDA];
               end
            end
            2'd3: begin
               r_next.scl_low = (r_reg.kind != K_STOP);
               r_next.bitn = r_reg.bitn + 4'h1;
               sym_end = (r_reg.kind == K_START) || (r_reg.kind == K_STOP)
                         || (r_reg.bitn == 4'h8);
            end
         endcase
      end

      // Advance to the next symbol; a refused byte skips to stop
      if (sym_end) begin
         if (r_reg.kind == K_STOP) begin
            r_next.busy = 1'b0;
            r_next.sel_n = 1'b1;
            r_next.rsp_data = r_reg.wr ? 8'h00 : r_reg.shreg;
            r_next.rsp_valid = ~r_reg.auto_rd;
            r_next.evt_valid = r_reg.auto_rd;
         end else begin
            nstep = r_reg.nack ? (r_reg.wr ? 3'd4 : 3'd6) : r_reg.step + 3'd1;
            nsym = sym_at(nstep, r_reg.wr, r_reg.reg_a, r_reg.data);
            r_next.step = nstep;
            r_next.kind = mmc_sym_t'(nsym[9:8]);
            // Keep the byte just read; the stop that follows carries none
            if (r_reg.kind != K_READ) begin
               r_next.shreg = nsym[7:0];
            end
            r_next.bitn = '0;
         end
      end
   end

   // ----------
   // State register
   // ----------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r_reg <= '0;
         r_reg.sync <= {3{H_PIN_IDLE}};
         r_reg.pin <= H_PIN_IDLE;
         r_reg.sel_n <= 1'b1;
         r_reg.pending <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------
   // Outputs
   // ----------
   assign link.scl_host_o = 1'b0;
   assign link.scl_host_oe_n = ~r_reg.scl_low;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe_n = ~r_reg.sda_low;
   assign link.module_select_n = r_reg.sel_n;
   assign link.module_reset_n = ~r_reg.rst_low;
   assign link.low_power_request = r_reg.lp;

   // Commands wait out resets and any attention still unserved
   assign cmd_ready = ~r_reg.busy & ~r_reg.pending & ~r_reg.rst_low & r_reg.pin[H_PIN_ATTN];
   assign rsp_valid = r_reg.rsp_valid;
   assign rsp_nack = r_reg.nack;
   assign rsp_rdata = r_reg.rsp_data;
   assign module_present = ~r_reg.pin[H_PIN_PRES];
   assign module_ready = ~r_reg.pending;
   assign event_valid = r_reg.evt_valid;
   assign event_flags = r_reg.rsp_data;

endmodule : mmc_host_end

`default_nettype wire

// ==== tb/mmc_asserts.sv ====
`default_nettype none

module mmc_asserts #(
   parameter int RESET_MIN_CYC = 20,
   parameter int INIT_CYC = 200
) (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Link wires
   input wire logic scl,
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic sda_dev_oe_n,
   input wire logic attention_o,
   input wire logic attention_oe_n,
   input wire logic present_o,
   input wire logic present_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // ----------
   // Reset pin low and high spans
   // ----------
   logic [15:0] low_cnt_reg;
   int hi_cnt_reg;

   // Saturating so the high span never wraps into the init window
   always_ff @(posedge clk) begin
      if (!rst_b || !module_reset_n) begin
         hi_cnt_reg <= 0;
      end else if (hi_cnt_reg < INIT_CYC + 21) begin
         hi_cnt_reg <= hi_cnt_reg + 1;
      end
      low_cnt_reg <= (!rst_b || module_reset_n) ? 16'h0000 : low_cnt_reg + 16'h0001;
   end

   // ----------
   // Properties
   // ----------
   property p_unsel_quiet;
      module_select_n [*6] |-> sda_dev_oe_n;
   endproperty
   a_unsel_quiet: assert property (p_unsel_quiet)
      else $error("data line driven while not selected");
   property p_scl_sel;
      $fell(scl) |-> !module_select_n;
   endproperty
   a_scl_sel: assert property (p_scl_sel)
      else $error("clock toggled with module not selected");
   property p_dev_edge;
      $changed(sda_dev_oe_n) |-> !scl;
   endproperty
   a_dev_edge: assert property (p_dev_edge)
      else $error("module changed data while clock high");
   property p_long_low;
      (low_cnt_reg > RESET_MIN_CYC + 6) |-> (sda_dev_oe_n && attention_oe_n);
   endproperty
   a_long_low: assert property (p_long_low)
      else $error("module active during held reset");
   property p_pulse_len;
      $rose(module_reset_n) |-> (low_cnt_reg > RESET_MIN_CYC + 6);
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse shorter than minimum");
   property p_no_early;
      (module_reset_n && hi_cnt_reg < INIT_CYC) |-> attention_oe_n;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("attention before init finished");
   property p_done_attn;
      (hi_cnt_reg == INIT_CYC + 20) |-> !attention_oe_n;
   endproperty
   a_done_attn: assert property (p_done_attn)
      else $error("no reset-done attention after init");
   property p_sink_only;
      !attention_oe_n |-> !attention_o;
   endproperty
   a_sink_only: assert property (p_sink_only)
      else $error("attention driven high");
   property p_present;
      !present_oe_n && !present_o;
   endproperty
   a_present: assert property (p_present)
      else $error("presence not pulled low");

endmodule : mmc_asserts

`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------
   // Signals
   // ----------
   logic clk, rst_b, cmd_valid, cmd_ready, cmd_write, rsp_valid, rsp_nack;
   logic reset_request, low_power_in, module_present, host_ready, event_valid;
   logic fault_event, mod_ready, high_power_allow;
   logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, event_flags, ctrl_byte, rd, ev_flags;
   int n_errors, total_checks, ev_cnt, c;
   // Offset, write value, read-back value; 0 and 8 must drop writes
   logic [7:0] ta[4] = '{8'h02, 8'h07, 8'h00, 8'h08};
   logic [7:0] tw[4] = '{8'ha5, 8'h3c, 8'hff, 8'h11};
   logic [7:0] te[4] = '{8'ha5, 8'h3c, 8'h00, 8'h00};

   mmc_link_if i_mmc_link_if ();

   mmc_module_end #(.RESET_MIN_CYC(20), .INIT_CYC(200)) i_mmc_module_end (
      .clk(clk), .rst_b(rst_b), .link(i_mmc_link_if), .fault_event(fault_event),
      .module_ready(mod_ready), .high_power_allow(high_power_allow), .ctrl_byte(ctrl_byte));

   mmc_host_end #(.QUARTER_CYC(8), .RESET_PULSE_CYC(40)) i_mmc_host_end (
      .clk(clk), .rst_b(rst_b), .link(i_mmc_link_if), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
      .rsp_rdata(rsp_rdata), .reset_request(reset_request), .low_power_in(low_power_in),
      .module_present(module_present), .module_ready(host_ready),
      .event_valid(event_valid), .event_flags(event_flags));

   // Checker defaults already match the module's simulation settings
   mmc_asserts i_mmc_asserts (
      .clk(clk), .rst_b(rst_b), .scl(i_mmc_link_if.scl),
      .module_select_n(i_mmc_link_if.module_select_n),
      .module_reset_n(i_mmc_link_if.module_reset_n),
      .sda_dev_oe_n(i_mmc_link_if.sda_dev_oe_n), .attention_o(i_mmc_link_if.attention_o),
      .attention_oe_n(i_mmc_link_if.attention_oe_n), .present_o(i_mmc_link_if.present_o),
      .present_oe_n(i_mmc_link_if.present_oe_n));

   // 100 MHz clock
   always #5 clk = ~clk;

   // Latch each automatic flag read by the host
   always @(negedge clk) begin
      if (event_valid === 1'b1) begin
         ev_cnt++;
         ev_flags = event_flags;
      end
   end

   // ----------
   // Tasks
   // ----------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Ready only changes at the rising edge, so looking at it mid-cycle is safe
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge clk);
      rd = rsp_rdata;
      chk("nack", {7'h00, rsp_nack}, 8'h00);
   endtask : xfer

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   // Whole run needs about 16000 cycles
   initial begin
      #800000;
      n_errors++;
      print_verdict();
   end

   // ----------
   // Tests
   // ----------
   initial begin
      {clk, cmd_valid, cmd_write, reset_request, low_power_in, fault_event} = '0;
      {cmd_addr, cmd_wdata} = '0;
      {rst_b, n_errors, total_checks, ev_cnt} = '0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      wait (ev_cnt > 0);
      chk("presence pin", {7'h00, i_mmc_link_if.module_present_n}, 8'h00);
      chk("present", {7'h00, module_present}, 8'h01);
      chk("power-up flags", ev_flags, 8'h01);
      xfer(1'b0, 8'h00, 8'h00);
      chk("status", rd, 8'h00);
      chk("ready", {7'h00, mod_ready}, 8'h01);
      $display("test power_up done");
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, ta[i], tw[i]);
         xfer(1'b0, ta[i], 8'h00);
         chk("map read", rd, te[i]);
      end
      chk("ctrl byte", ctrl_byte, 8'ha5);
      $display("test map done");
      chk("high power", {7'h00, high_power_allow}, 8'h01);
      low_power_in = 1'b1;
      repeat (10) @(negedge clk);
      chk("low power", {7'h00, high_power_allow}, 8'h00);
      low_power_in = 1'b0;
      c = ev_cnt;
      fault_event = 1'b1;
      @(negedge clk);
      fault_event = 1'b0;
      wait (ev_cnt > c);
      chk("fault flags", ev_flags, 8'h02);
      $display("test power_fault done");
      c = ev_cnt;
      reset_request = 1'b1;
      @(negedge clk);
      reset_request = 1'b0;
      repeat (2) @(negedge clk);
      chk("host ready", {7'h00, host_ready}, 8'h00);
      wait (ev_cnt > c);
      chk("reset flags", ev_flags, 8'h01);
      chk("ctrl default", ctrl_byte, 8'h00);
      xfer(1'b0, 8'h07, 8'h00);
      chk("scratch default", rd, 8'h00);
      $display("test reset done");
      print_verdict();
   end

endmodule : tb_top

`default_nettype wire
